/* rtl/asrx_regs.svh */
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   definitions only
`ifndef ASRX_REGS_SVH
`define ASRX_REGS_SVH
// ==========================================================
// register byte offsets
`define ASRX_OFF_RXDATA   12'h000
`define ASRX_OFF_RXSTAT   12'h004
`define ASRX_OFF_TXSTAT   12'h008
`define ASRX_OFF_BAUD     12'h00c
`define ASRX_OFF_IRQEN    12'h010
`define ASRX_OFF_FLAGS    12'h014
// ==========================================================
// receive status/control fields
`define ASRX_RS_SERIAL_PORT_ENABLE      7
`define ASRX_RS_RX9       6
`define ASRX_RS_CONTINUOUS_RX_ENABLE      4
`define ASRX_RS_FRAMING_ERROR_FLAG      2
`define ASRX_RS_OVERRUN_ERROR_FLAG      1
`define ASRX_RS_RX_NINTH_BIT      0
// transmit status/control fields
`define ASRX_TS_CLOCK_SOURCE_SELECT      7
`define ASRX_TS_TX9       6
`define ASRX_TS_TRANSMIT_ENABLE      5
`define ASRX_TS_SYNC      4
`define ASRX_TS_HIGH_SPEED_BAUD      2
`define ASRX_TS_SHIFT_EMPTY_FLAG      1
`define ASRX_TS_TX_NINTH_BIT      0
// interrupt enable fields
`define ASRX_IE_GIE       2
`define ASRX_IE_PERIPHERAL_IRQ_ENABLE      1
`define ASRX_IE_RX_IRQ_ENABLE      0
// ==========================================================
// reset values
`define ASRX_TS_RESET     8'h02
`define ASRX_BAUD_RESET   8'h19
// low speed: one bit lasts 64 oscillator periods per divisor step
`define ASRX_LOW_MULT     7'h40
`define ASRX_HIGH_MULT    7'h10
`endif

/* rtl/asrx_pkg.sv */
// Purpose: shared types of the serial receiver
// Assumes: nothing
// Notes:   constants live in asrx_regs.svh
package asrx_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asrx_state_t;
  typedef struct packed {
    logic       framing_error_flag;
    logic [8:0] data;
  } asrx_entry_t;
endpackage

/* rtl/asrx_fifo_if.sv */
// Purpose: push/pop carrier between receiver and its FIFO
// Assumes: single clock
// Notes:   none
`timescale 1ns/10ps
`default_nettype none
interface asrx_fifo_if;
  import asrx_pkg::*;
  logic        push;
  asrx_entry_t push_entry;
  logic        pop;
  logic        flush;
  asrx_entry_t head;
  logic [1:0]  count;
  modport owner (output push, output push_entry, output pop, output flush,
                 input head, input count);
  modport store (input push, input push_entry, input pop, input flush,
                 output head, output count);
endinterface
`default_nettype wire

/* rtl/asrx_fifo.sv */
// Purpose: two-entry receive FIFO, head out of a register
// Assumes: push never issued while full unless a pop comes in the same cycle
// Notes:   each entry carries its own framing bit
`timescale 1ns/10ps
`default_nettype none
module asrx_fifo
  import asrx_pkg::*;
#(
  parameter int DEPTH = 2
)(
  // clock and reset
  input  wire logic   pclk,
  input  wire logic   presetn,
  // carrier
  asrx_fifo_if.store  fif
);
  asrx_entry_t mem_reg [DEPTH];
  logic [1:0]  count_reg;
  // ==========================================================
  // storage: shift on pop, write at tail
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < DEPTH; i++) mem_reg[i] <= '0;
      count_reg <= 2'h0;
    end
    else if (fif.flush)
    begin
      count_reg <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        if (fif.pop && count_reg != 2'h0)
        begin
          if (fif.push && 2'(i) == count_reg - 2'h1) mem_reg[i] <= fif.push_entry;
          else if (i < DEPTH - 1) mem_reg[i] <= mem_reg[i + 1];
        end
        else if (fif.push && 2'(i) == count_reg)
        begin
          mem_reg[i] <= fif.push_entry;
        end
      end
      count_reg <= count_reg + 2'(fif.push) - 2'(fif.pop && count_reg != 2'h0);
    end
  end
  assign fif.head  = mem_reg[0];
  assign fif.count = count_reg;
endmodule // asrx_fifo
`default_nettype wire

/* rtl/asrx_top.sv */
// Purpose: asynchronous serial receiver with transmit control fields, APB slave
// Assumes: rx_line synchronous to pclk, idle high
// Notes:
`timescale 1ns/10ps
`include "asrx_regs.svh"
`default_nettype none
module asrx_top
  import asrx_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial line and interrupt
  input  wire logic        rx_line,
  output logic             rx_irq
);
  asrx_fifo_if fif ();
  asrx_fifo #(.DEPTH(2)) u_fifo (.pclk(pclk), .presetn(presetn), .fif(fif));

  // ==========================================================
  // registers
  logic [7:0]  rxctl_reg;     // serial_port_enable, rx9, continuous_rx_enable
  logic [7:0]  txctl_reg;
  logic [7:0]  baud_divisor_reg;
  logic [2:0]  irqen_reg;
  logic        overrun_reg;
  logic        line_reg;
  asrx_state_t state_reg;
  logic [14:0] tick_reg;
  logic [3:0]  bitn_reg;
  logic [8:0]  receive_shift_reg;
  logic [2:0]  vote_reg;

  logic serial_port_enable, continuous_rx_enable, rx_nine_bit_select, rx_on;
  assign serial_port_enable   = rxctl_reg[`ASRX_RS_SERIAL_PORT_ENABLE];
  assign continuous_rx_enable = rxctl_reg[`ASRX_RS_CONTINUOUS_RX_ENABLE];
  assign rx_nine_bit_select   = rxctl_reg[`ASRX_RS_RX9];
  assign rx_on = serial_port_enable && continuous_rx_enable;

  // access strobes
  logic wr_acc, rd_acc;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;

  // ==========================================================
  // bit timing: samples per bit = mult * (divisor + 1)
  // 15 bits so that 64 * 256 does not wrap to zero
  logic [14:0] bit_ticks, half_ticks;
  always_comb
  begin
    // high_speed_baud only counts in asynchronous mode
    if (txctl_reg[`ASRX_TS_HIGH_SPEED_BAUD] && !txctl_reg[`ASRX_TS_SYNC])
      bit_ticks = 15'(`ASRX_HIGH_MULT) * (15'(baud_divisor_reg) + 15'h1);
    else
      bit_ticks = 15'(`ASRX_LOW_MULT) * (15'(baud_divisor_reg) + 15'h1);
    half_ticks = bit_ticks >> 1;
  end

  // majority of the three samples around the centre
  logic maj;
  assign maj = (vote_reg[0] & vote_reg[1]) | (vote_reg[1] & vote_reg[2])
             | (vote_reg[0] & vote_reg[2]);

  logic at_centre;
  assign at_centre = (tick_reg == 15'h0);
  logic [3:0] last_bit;
  assign last_bit = rx_nine_bit_select ? 4'h8 : 4'h7;

  // ==========================================================
  // receive state machine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg         <= RX_IDLE;
      tick_reg          <= 15'h0;
      bitn_reg          <= 4'h0;
      receive_shift_reg <= 9'h000;
      line_reg          <= 1'b1;
      vote_reg          <= 3'h7;
    end
    else
    begin
      line_reg <= rx_line;
      vote_reg <= {vote_reg[1:0], rx_line};
      if (!rx_on || overrun_reg)
      begin
        state_reg <= RX_IDLE;
      end
      else
      begin
        if (tick_reg != 15'h0) tick_reg <= tick_reg - 15'h1;
        case (state_reg)
          RX_IDLE:
            if (line_reg && !rx_line)
            begin
              state_reg <= RX_START;
              tick_reg  <= half_ticks;
            end
          RX_START:
            if (at_centre)
            begin
              if (maj) state_reg <= RX_IDLE;
              else
              begin
                state_reg <= RX_DATA;
                tick_reg  <= bit_ticks - 15'h1;
                bitn_reg  <= 4'h0;
              end
            end
          RX_DATA:
            if (at_centre)
            begin
              // lsb first: new bit enters at top, result right-aligned later
              receive_shift_reg <= {maj, receive_shift_reg[8:1]};
              tick_reg <= bit_ticks - 15'h1;
              if (bitn_reg == last_bit) state_reg <= RX_STOP;
              bitn_reg <= bitn_reg + 4'h1;
            end
          RX_STOP:
            if (at_centre) state_reg <= RX_IDLE;
          default: state_reg <= RX_IDLE;
        endcase
      end
    end
  end

  // character complete at stop centre
  logic char_done;
  assign char_done = rx_on && !overrun_reg && state_reg == RX_STOP && at_centre;

  // ==========================================================
  // FIFO push/pop
  logic pop_req;
  assign pop_req = rd_acc && paddr == `ASRX_OFF_RXDATA;
  always_comb
  begin
    // a pop in the same cycle frees a slot for the finished character
    fif.push = char_done && (fif.count != 2'h2 || pop_req);
    fif.push_entry.framing_error_flag = !maj;
    fif.push_entry.data = rx_nine_bit_select ? receive_shift_reg
                                             : {1'b0, receive_shift_reg[8:1]};
    fif.pop   = pop_req;
    fif.flush = !serial_port_enable;
  end

  // overrun: third character with FIFO full
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) overrun_reg <= 1'b0;
    else if (!rx_on) overrun_reg <= 1'b0;
    else if (char_done && fif.count == 2'h2 && !pop_req) overrun_reg <= 1'b1;
  end

  // ==========================================================
  // software writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxctl_reg        <= 8'h00;
      txctl_reg        <= `ASRX_TS_RESET;
      baud_divisor_reg <= `ASRX_BAUD_RESET;
      irqen_reg        <= 3'h0;
    end
    else if (wr_acc)
    begin
      if (paddr == `ASRX_OFF_RXSTAT)
        rxctl_reg <= pwdata[7:0] & 8'hd0;
      else if (paddr == `ASRX_OFF_TXSTAT)
        // shift_empty_flag stays one: no transmit shifter here
        txctl_reg <= (pwdata[7:0] & 8'hf5) | 8'h02;
      else if (paddr == `ASRX_OFF_BAUD)
        baud_divisor_reg <= pwdata[7:0];
      else if (paddr == `ASRX_OFF_IRQEN)
        irqen_reg <= pwdata[2:0];
    end
  end

  // ==========================================================
  // read mux, zero-wait answer
  logic rx_pending_flag;
  assign rx_pending_flag = rx_on && fif.count != 2'h0;
  logic [7:0] rxstat_view;
  assign rxstat_view = {rxctl_reg[7:3],
                        fif.count != 2'h0 && fif.head.framing_error_flag,
                        overrun_reg,
                        fif.count != 2'h0 && fif.head.data[8]};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
      begin
        if (paddr == `ASRX_OFF_RXDATA)
          prdata <= {24'h0, fif.head.data[7:0]};
        else if (paddr == `ASRX_OFF_RXSTAT)
          prdata <= {24'h0, rxstat_view};
        else if (paddr == `ASRX_OFF_TXSTAT)
          prdata <= {24'h0, txctl_reg};
        else if (paddr == `ASRX_OFF_BAUD)
          prdata <= {24'h0, baud_divisor_reg};
        else if (paddr == `ASRX_OFF_IRQEN)
          prdata <= {29'h0, irqen_reg};
        else if (paddr == `ASRX_OFF_FLAGS)
          prdata <= {31'h0, rx_pending_flag};
        else
          pslverr <= 1'b1;
      end
      else if (psel && !penable)
      begin
        pslverr <= !(paddr == `ASRX_OFF_RXSTAT || paddr == `ASRX_OFF_TXSTAT
                  || paddr == `ASRX_OFF_BAUD || paddr == `ASRX_OFF_IRQEN
                  || paddr == `ASRX_OFF_RXDATA || paddr == `ASRX_OFF_FLAGS);
      end
    end
  end

  // interrupt: pending gated by three enables, framing not included
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) rx_irq <= 1'b0;
    else rx_irq <= rx_pending_flag && irqen_reg[`ASRX_IE_RX_IRQ_ENABLE]
                && irqen_reg[`ASRX_IE_PERIPHERAL_IRQ_ENABLE] && irqen_reg[`ASRX_IE_GIE];
  end

  // ==========================================================
  // checks
  chk_irq_gating: assert property (@(posedge pclk) disable iff (!presetn)
    rx_irq |-> $past(rx_pending_flag) && $past(irqen_reg) == 3'h7)
    else $error("interrupt without pending and all enables");
  chk_pend_track: assert property (@(posedge pclk) disable iff (!presetn)
    rx_pending_flag == (rx_on && fif.count != 2'h0))
    else $error("pending flag mismatch");
  chk_push_sets: assert property (@(posedge pclk) disable iff (!presetn)
    fif.push && !pop_req |=> fif.count != 2'h0)
    else $error("push did not fill fifo");
  chk_overrun_set: assert property (@(posedge pclk) disable iff (!presetn)
    char_done && fif.count == 2'h2 && !pop_req |=> overrun_reg)
    else $error("overrun not flagged");
  chk_overrun_block: assert property (@(posedge pclk) disable iff (!presetn)
    overrun_reg |-> !fif.push && state_reg == RX_IDLE)
    else $error("push during overrun");
  chk_overrun_clear: assert property (@(posedge pclk) disable iff (!presetn)
    !rx_on |=> !overrun_reg)
    else $error("overrun kept after disable");
  chk_serial_port_enable_flush: assert property (@(posedge pclk) disable iff (!presetn)
    !serial_port_enable |=> fif.count == 2'h0 && rxstat_view[`ASRX_RS_FRAMING_ERROR_FLAG] == 1'b0)
    else $error("port disable left data");
  chk_false_start: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == RX_START && at_centre && maj && rx_on && !overrun_reg
    |=> state_reg == RX_IDLE && !overrun_reg)
    else $error("false start not dropped");
  chk_shift_empty_flag_one: assert property (@(posedge pclk) disable iff (!presetn)
    txctl_reg[`ASRX_TS_SHIFT_EMPTY_FLAG])
    else $error("shift empty not one");
  chk_start_seen: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == RX_IDLE && rx_on && !overrun_reg && line_reg && !rx_line
    |=> state_reg == RX_START)
    else $error("falling edge did not start a character");
  chk_pop_advance: assert property (@(posedge pclk) disable iff (!presetn)
    pop_req && serial_port_enable && fif.count == 2'h2 && !fif.push
    |=> fif.count == 2'h1)
    else $error("read did not remove oldest character");
  cov_char: cover property (@(posedge pclk) disable iff (!presetn) fif.push);
  cov_framing_error_flag: cover property (@(posedge pclk) disable iff (!presetn)
    fif.push && fif.push_entry.framing_error_flag);
  cov_ovr: cover property (@(posedge pclk) disable iff (!presetn) $rose(overrun_reg));
  cov_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(rx_irq));
  cov_nine: cover property (@(posedge pclk) disable iff (!presetn)
    fif.push && rx_nine_bit_select);
endmodule // asrx_top
`default_nettype wire

/* verification/asrx_serial_src.sv */
// Purpose: remote serial transmitter that drives the receive line
// Assumes: line idles high; bit time is set in pclk cycles
// Notes:   one start bit, 8 or 9 data bits lsb first, one stop bit
`timescale 1ns/10ps
`default_nettype none
module asrx_serial_src (
  // clock
  input  wire logic pclk,
  // serial line
  output logic      rx_line
);
  int bit_cyc;
  // ==========================================================
  // idle state
  initial
  begin
    bit_cyc = 16;
    rx_line = 1'b1;
  end
  // hold one level for one bit time, changed just after an edge
  task automatic put_bit(input logic v);
    rx_line <= v;
    repeat (bit_cyc) @(posedge pclk);
  endtask
  // whole frame; a low stop level makes a framing fault
  task automatic send(input logic [8:0] d, input int nb, input logic stop);
    @(posedge pclk);
    put_bit(1'b0);
    for (int i = 0; i < nb; i++)
      put_bit(d[i]);
    put_bit(stop);
    put_bit(1'b1);
  endtask
  // low pulse that is over well before mid-start
  task automatic glitch();
    @(posedge pclk);
    rx_line <= 1'b0;
    repeat (bit_cyc / 4) @(posedge pclk);
    put_bit(1'b1);
  endtask
endmodule // asrx_serial_src
`default_nettype wire

/* verification/tb_async_serial_receiver_and_tx_control.sv */
// Purpose: self-checking bench of the serial receiver and its registers
// Assumes: apb answers in one access cycle; fast baud used to keep runs short
// Notes:   expected reads are queued by the driver and checked by a monitor
`timescale 1ns/10ps
`include "asrx_regs.svh"
`default_nettype none
module tb_async_serial_receiver_and_tx_control
  import asrx_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, rx_line, pready, pslverr, rx_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, tmp;
  logic [33:0] exp_q[$];
  logic [33:0] e_cur;
  logic [8:0]  ch [3];
  int          failures, checks_done;
  // ==========================================================
  // design and far side
  asrx_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_line(rx_line), .rx_irq(rx_irq));
  asrx_serial_src src (.pclk(pclk), .rx_line(rx_line));
  // 40 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check_rd(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; e = {check data, error, data}
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // hold the request until the answer; only the watchdog ends a hang
    while (pready !== 1'b1)
      @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] v);
    apb(1'b0, a, 32'h0, {2'b10, v});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    apb(1'b1, a, v, {2'b00, 32'h0});
  endtask
  task automatic stop_test();
    if (exp_q.size() != 0)
      failures++;
    $display("checks_done %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================================
  // monitor: oldest note against each answer
  always @(posedge pclk)
    if (pready === 1'b1)
    begin
      e_cur = (exp_q.size() != 0) ? exp_q.pop_front() : 34'h3ffffffff;
      check_rd({pslverr, e_cur[33] ? prdata : 32'h0}, e_cur[32:0]);
    end
  // watchdog
  initial
  begin
    repeat (40000) @(posedge pclk);
    failures++;
    stop_test();
  end
  // ==========================================================
  // main sequence
  initial
  begin
    seed = 32'd48811;
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    failures = 0;
    checks_done = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ASRX_OFF_TXSTAT, 32'h02);
    rd(`ASRX_OFF_BAUD, 32'h19);
    apb(1'b0, 12'h018, 32'h0, {2'b11, 32'h0}); // unmapped read
    apb(1'b1, 12'h018, 32'hff, {2'b01, 32'h0}); // unmapped write
    wr(`ASRX_OFF_TXSTAT, 32'hff);
    rd(`ASRX_OFF_TXSTAT, 32'hf7);
    wr(`ASRX_OFF_TXSTAT, 32'h04); // high speed, async
    wr(`ASRX_OFF_BAUD, 32'h0);
    rd(`ASRX_OFF_BAUD, 32'h0);
    wr(`ASRX_OFF_RXSTAT, 32'h90);
    // good character then one with a low stop level
    for (int i = 0; i < 2; i++)
    begin
      tmp = xs();
      ch[i] = {1'b0, tmp[7:0]};
    end
    src.send(ch[0], 8, 1'b1);
    src.send(ch[1], 8, 1'b0);
    rd(`ASRX_OFF_FLAGS, 32'h1);
    rd(`ASRX_OFF_RXSTAT, 32'h90);
    rd(`ASRX_OFF_RXDATA, {24'h0, ch[0][7:0]});
    rd(`ASRX_OFF_RXSTAT, 32'h94);
    // every combination of the three enables
    for (int k = 0; k < 8; k++)
    begin
      wr(`ASRX_OFF_IRQEN, 32'(k));
      repeat (2) @(posedge pclk);
      #1 check_bit(rx_irq, k == 7);
    end
    wr(`ASRX_OFF_RXSTAT, 32'h80);
    rd(`ASRX_OFF_RXSTAT, 32'h84);
    wr(`ASRX_OFF_RXSTAT, 32'h00);
    rd(`ASRX_OFF_RXSTAT, 32'h00);
    rd(`ASRX_OFF_FLAGS, 32'h0);
    // false start, then four characters: two kept, the third overruns, the fourth is ignored
    wr(`ASRX_OFF_RXSTAT, 32'h90);
    src.glitch();
    for (int i = 0; i < 3; i++)
    begin
      tmp = xs();
      ch[i] = {1'b0, tmp[7:0]};
      src.send(ch[i], 8, 1'b1);
    end
    src.send(9'h055, 8, 1'b1);
    rd(`ASRX_OFF_RXSTAT, 32'h92);
    rd(`ASRX_OFF_RXDATA, {24'h0, ch[0][7:0]});
    rd(`ASRX_OFF_RXDATA, {24'h0, ch[1][7:0]});
    rd(`ASRX_OFF_FLAGS, 32'h0);
    wr(`ASRX_OFF_RXSTAT, 32'h80);
    wr(`ASRX_OFF_RXSTAT, 32'h90);
    rd(`ASRX_OFF_RXSTAT, 32'h90);
    // nine-bit character
    wr(`ASRX_OFF_RXSTAT, 32'hd0);
    tmp = xs();
    ch[0] = tmp[8:0];
    src.send(ch[0], 9, 1'b1);
    rd(`ASRX_OFF_RXSTAT, {31'h68, ch[0][8]});
    rd(`ASRX_OFF_RXDATA, {24'h0, ch[0][7:0]});
    repeat (4) @(posedge pclk);
    stop_test();
  end
endmodule // tb_async_serial_receiver_and_tx_control
`default_nettype wire
